// *** core/ecl_pkg.sv ***
// Purpose: Shared constants and carriers for the engine command/status link.
// Assumes: 200 MHz system clock, 9600 bit/s serial link.
// Notes:   All timing counts derive from the clock rate and the bit rate.
package ecl_pkg;
	localparam int unsigned CLK_HZ      = 200_000_000;
	localparam int unsigned BAUD_BPS    = 9600;
	localparam int unsigned BIT_CYCLES  = CLK_HZ / BAUD_BPS;
	localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
	localparam int unsigned CNT_W       = 15;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned FRAME_BITS  = 11;
	localparam logic [7:0]  INIT_CMD    = 8'h00; // Default init command code, overridable at the top
	localparam logic        LINE_IDLE   = 1'b1;

	// One received status frame with its check result
	typedef struct packed {
		logic [7:0] data;
		logic       parityErr;
		logic       stopErr;
	} ecl_rx_t;

	// Sideband levels received from the engine
	typedef struct packed {
		logic engineReady;
		logic keyChange;
		logic vsync;
		logic hsync;
	} ecl_side_t;
endpackage

// *** core/ecl_tx.sv ***
// Purpose: Serial frame sender for the command line.
// Assumes: Bit period given in clock cycles.
// Notes:   Start, 8 data LSB first, odd parity, stop.
`timescale 1ns/1ps
`default_nettype none
module ecl_tx import ecl_pkg::*; #(
	parameter int unsigned BIT_CYC = BIT_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       startTx,
	input  wire logic [7:0] txData,
	output logic            txLine,
	output logic            txBusy
);
	logic [10:0]      shift_reg;
	logic [3:0]       bitCnt_reg;
	logic [CNT_W-1:0] cyc_reg;
	logic             busy_reg;
	wire              bitEnd = (cyc_reg == CNT_W'(BIT_CYC - 1));
	wire              oddPar = ~^txData;

	// Frame shifter; the line idles high between frames
	always_ff @(posedge clk) begin
		if (rst) begin
			shift_reg  <= '1;
			bitCnt_reg <= 4'h0;
			cyc_reg    <= '0;
			busy_reg   <= 1'b0;
		end else if (!busy_reg) begin
			cyc_reg <= '0;
			if (startTx) begin
				shift_reg  <= {1'b1, oddPar, txData, 1'b0};
				bitCnt_reg <= 4'h0;
				busy_reg   <= 1'b1;
			end
		end else if (bitEnd) begin
			cyc_reg    <= '0;
			shift_reg  <= {1'b1, shift_reg[10:1]};
			bitCnt_reg <= bitCnt_reg + 4'h1;
			if (bitCnt_reg == 4'(FRAME_BITS - 1))
				busy_reg <= 1'b0;
		end else begin
			cyc_reg <= cyc_reg + CNT_W'(1);
		end
	end

	assign txLine = busy_reg ? shift_reg[0] : LINE_IDLE;
	assign txBusy = busy_reg;

	property p_txStart;
		@(posedge clk) disable iff (rst) (startTx && !busy_reg) |=> (txLine == 1'b0) && busy_reg;
	endproperty
	a_txStart: assert property (p_txStart) else $error("start bit not driven low");

	property p_txParity;
		@(posedge clk) disable iff (rst) (startTx && !busy_reg) |=> ^shift_reg[9:1];
	endproperty
	a_txParity: assert property (p_txParity) else $error("parity not odd");
endmodule // ecl_tx
`default_nettype wire

// *** core/ecl_rx.sv ***
// Purpose: Serial frame receiver for the status line.
// Assumes: Line already synchronous to clk, idles high.
// Notes:   Samples at bit centres; flags parity and stop errors.
`timescale 1ns/1ps
`default_nettype none
module ecl_rx import ecl_pkg::*; #(
	parameter int unsigned BIT_CYC = BIT_CYCLES
) (
	input  wire logic    clk,
	input  wire logic    rst,
	input  wire logic    rxLine,
	output ecl_rx_t      rxFrame,
	output logic         rxValid
);
	logic [9:0]       shift_reg;
	logic [3:0]       bitCnt_reg;
	logic [CNT_W-1:0] cyc_reg;
	logic             busy_reg;
	logic             valid_reg;
	ecl_rx_t          frame_reg;
	wire  [CNT_W-1:0] target = busy_reg && bitCnt_reg == 4'h0 ? CNT_W'(BIT_CYC / 2 - 1) : CNT_W'(BIT_CYC - 1);
	wire              sampleNow = busy_reg && (cyc_reg == target);
	wire              lastBit = (bitCnt_reg == 4'(FRAME_BITS - 1));

	// Start detect, then centre sampling of each bit
	always_ff @(posedge clk) begin
		if (rst) begin
			shift_reg  <= '0;
			bitCnt_reg <= 4'h0;
			cyc_reg    <= '0;
			busy_reg   <= 1'b0;
			valid_reg  <= 1'b0;
			frame_reg  <= '0;
		end else begin
			valid_reg <= 1'b0;
			if (!busy_reg) begin
				cyc_reg    <= '0;
				bitCnt_reg <= 4'h0;
				busy_reg   <= (rxLine == 1'b0);
			end else if (sampleNow) begin
				cyc_reg    <= '0;
				bitCnt_reg <= bitCnt_reg + 4'h1;
				shift_reg  <= {rxLine, shift_reg[9:1]};
				// A start bit gone high at its centre was a glitch
				if (bitCnt_reg == 4'h0 && rxLine)
					busy_reg <= 1'b0;
				if (lastBit) begin
					busy_reg            <= 1'b0;
					valid_reg           <= 1'b1;
					// Start bit is the oldest sample in bit 0, parity the newest in bit 9
					frame_reg.data      <= shift_reg[8:1];
					frame_reg.parityErr <= ~^shift_reg[9:1];
					frame_reg.stopErr   <= ~rxLine;
				end
			end else begin
				cyc_reg <= cyc_reg + CNT_W'(1);
			end
		end
	end

	assign rxFrame = frame_reg;
	assign rxValid = valid_reg;

	property p_rxCheck;
		@(posedge clk) disable iff (rst) rxValid |-> (rxFrame.parityErr == ~^{rxFrame.data, $past(shift_reg[9])});
	endproperty
	a_rxCheck: assert property (p_rxCheck) else $error("parity flag wrong");
endmodule // ecl_rx
`default_nettype wire

// *** core/ecl_link.sv ***
// Purpose: Controller end of the engine command/status link with sideband.
// Assumes: All engine pins synchronous to clk; active-high levels here.
// Notes:   One command in flight; the next waits for the status answer.
//
// Functional notes
// - Print request asserted while page wanted; code also needs engine ready and link up
// - Vertical sync aligns page image start
// - Video bits sent per horizontal sync line
// - Commands leave only on command line
// - Half duplex: one frame in flight
// - Both directions run at 9600 bit/s
// - Start, 8 data LSB first, parity, stop
// - Parity odd over data plus parity
// - Command then status handshake order kept
// - Initialization command sent first after reset
`timescale 1ns/1ps
`default_nettype none
module ecl_link import ecl_pkg::*; #(
	parameter int unsigned BIT_CYC   = BIT_CYCLES,
	parameter logic [7:0]  INIT_CODE = INIT_CMD,
	parameter int unsigned LINE_PIX  = 16
) (
	input  wire logic       clk,
	input  wire logic       rst,
	// Controller side
	input  wire logic       cmdValid,
	input  wire logic [7:0] cmdData,
	output logic            cmdReady,
	output logic [7:0]      statusData,
	output logic            statusValid,
	output logic            statusErr,
	output logic            linkUp,
	input  wire logic       pageWanted,
	input  wire logic [LINE_PIX-1:0] lineBits,
	output logic            lineTake,
	output logic            pageStart,
	output ecl_side_t       sideState,
	// Engine side
	input  wire logic       engineReadyInd,
	input  wire logic       keyStatus,
	input  wire logic       vsyncIn,
	input  wire logic       hsyncIn,
	input  wire logic       statusLine,
	output logic            commandLine,
	output logic            printRequest,
	output logic            videoOut
);
	typedef enum logic [3:0] {
		ST_INIT = 4'b0001,
		ST_SEND = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_IDLE = 4'b1000
	} ecl_state_t;

	ecl_state_t                  state_reg;
	ecl_state_t                  state_next;
	logic                        linkUp_reg;
	logic [7:0]                  txByte_reg;
	logic [7:0]                  stData_reg;
	logic                        stValid_reg;
	logic                        stErr_reg;
	logic                        vsPrev_reg;
	logic                        hsPrev_reg;
	logic                        inPage_reg;
	logic [LINE_PIX-1:0]         vid_reg;
	logic [$clog2(LINE_PIX+1)-1:0] pix_reg;
	logic [CNT_W-1:0]            pixCyc_reg;
	logic                        txBusy;
	logic                        rxValid;
	ecl_rx_t                     rxFrame;

	// Sender and receiver share the same bit timing
	ecl_tx #(.BIT_CYC(BIT_CYC)) u_tx (
		.clk    (clk),
		.rst    (rst),
		.startTx(state_reg == ST_SEND && !txBusy),
		.txData (txByte_reg),
		.txLine (commandLine),
		.txBusy (txBusy)
	);

	ecl_rx #(.BIT_CYC(BIT_CYC)) u_rx (
		.clk    (clk),
		.rst    (rst),
		.rxLine (statusLine),
		.rxFrame(rxFrame),
		.rxValid(rxValid)
	);

	// Handshake, sync edge and video step decode
	wire startSent  = (state_reg == ST_SEND) && !txBusy;
	wire answerSeen = (state_reg == ST_WAIT) && rxValid;
	wire takeCmd    = (state_reg == ST_IDLE) && cmdValid;
	wire vsRise     = vsyncIn && !vsPrev_reg;
	wire hsRise     = hsyncIn && !hsPrev_reg;
	wire pixStep    = (pix_reg != '0) && (pixCyc_reg == CNT_W'(BIT_CYC - 1));

	// Exchange sequencing: init first, then one command per status answer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_INIT: state_next = ST_SEND;
			ST_SEND: begin
				if (startSent)
					state_next = ST_WAIT;
			end
			ST_WAIT: begin
				// Status frame only accepted after our command
				if (answerSeen && !txBusy)
					state_next = ST_IDLE;
			end
			ST_IDLE: begin
				if (takeCmd)
					state_next = ST_SEND;
			end
			default: state_next = ST_INIT;
		endcase
	end

	// State register; any reset restarts with the init exchange
	always_ff @(posedge clk) begin
		if (rst)
			state_reg <= ST_INIT;
		else
			state_reg <= state_next;
	end

	// Command byte, link state and status capture
	always_ff @(posedge clk) begin
		if (rst) begin
			txByte_reg  <= 8'h00;
			linkUp_reg  <= 1'b0;
			stData_reg  <= 8'h00;
			stValid_reg <= 1'b0;
			stErr_reg   <= 1'b0;
		end else begin
			stValid_reg <= 1'b0;
			if (state_reg == ST_INIT)
				txByte_reg <= INIT_CODE;
			else if (takeCmd)
				txByte_reg <= cmdData;
			if (answerSeen) begin
				linkUp_reg  <= 1'b1;
				stData_reg  <= rxFrame.data;
				stValid_reg <= 1'b1;
				stErr_reg   <= rxFrame.parityErr | rxFrame.stopErr;
			end
		end
	end

	// Sideband: sync edges and video line shifter
	always_ff @(posedge clk) begin
		if (rst) begin
			vsPrev_reg <= 1'b0;
			hsPrev_reg <= 1'b0;
			inPage_reg <= 1'b0;
			vid_reg    <= '0;
			pix_reg    <= '0;
			pixCyc_reg <= '0;
		end else begin
			vsPrev_reg <= vsyncIn;
			hsPrev_reg <= hsyncIn;
			if (vsRise)
				inPage_reg <= 1'b1;
			else if (!pageWanted)
				inPage_reg <= 1'b0;
			if (hsRise && inPage_reg) begin
				vid_reg    <= lineBits;
				pix_reg    <= ($clog2(LINE_PIX+1))'(LINE_PIX);
				pixCyc_reg <= '0;
			end else if (pixStep) begin
				vid_reg    <= vid_reg >> 1;
				pix_reg    <= pix_reg - 1'b1;
				pixCyc_reg <= '0;
			end else if (pix_reg != '0) begin
				pixCyc_reg <= pixCyc_reg + CNT_W'(1);
			end
		end
	end

	// Outputs; video is idle low outside a line
	assign cmdReady     = (state_reg == ST_IDLE);
	assign statusData   = stData_reg;
	assign statusValid  = stValid_reg;
	assign statusErr    = stErr_reg;
	assign linkUp       = linkUp_reg;
	assign printRequest = pageWanted && engineReadyInd && linkUp_reg;
	assign lineTake     = hsRise && inPage_reg;
	assign pageStart    = vsRise && pageWanted;
	assign videoOut     = (pix_reg != '0) ? vid_reg[0] : 1'b0;
	assign sideState    = '{engineReady: engineReadyInd, keyChange: keyStatus, vsync: vsyncIn, hsync: hsyncIn};

	property p_initFirst;
		@(posedge clk) disable iff (rst) $rose(txBusy) && !linkUp_reg |-> (txByte_reg == INIT_CODE);
	endproperty
	a_initFirst: assert property (p_initFirst) else $error("first command not init");

	property p_oneInFlight;
		@(posedge clk) disable iff (rst) cmdValid && !cmdReady && (state_reg != ST_INIT) |=> $stable(txByte_reg);
	endproperty
	a_oneInFlight: assert property (p_oneInFlight) else $error("command taken before answer");

	property p_printGate;
		@(posedge clk) disable iff (rst) printRequest |-> engineReadyInd && linkUp_reg;
	endproperty
	a_printGate: assert property (p_printGate) else $error("print request without ready");

	property p_printReq;
		@(posedge clk) disable iff (rst) (pageWanted && engineReadyInd && linkUp_reg) |-> printRequest;
	endproperty
	a_printReq: assert property (p_printReq) else $error("print request missing");

	property p_lineLoad;
		@(posedge clk) disable iff (rst) lineTake |=> (pix_reg == ($clog2(LINE_PIX+1))'(LINE_PIX));
	endproperty
	a_lineLoad: assert property (p_lineLoad) else $error("line not loaded at hsync");

	property p_pageMark;
		@(posedge clk) disable iff (rst) (vsRise) |=> inPage_reg;
	endproperty
	a_pageMark: assert property (p_pageMark) else $error("vsync did not open page");

	property p_cmdIdle;
		@(posedge clk) disable iff (rst) !txBusy && !$past(txBusy) |-> commandLine;
	endproperty
	a_cmdIdle: assert property (p_cmdIdle) else $error("command line not idle");

	// Exchange order: a frame leaves only from the send state, one at a time
	property p_txFromSend;
		@(posedge clk) disable iff (rst) $rose(txBusy) |-> ($past(state_reg) == ST_SEND);
	endproperty
	a_txFromSend: assert property (p_txFromSend) else $error("frame started outside send state");

	property p_sendStarts;
		@(posedge clk) disable iff (rst) (state_reg == ST_SEND) && !txBusy |=> txBusy && (state_reg == ST_WAIT);
	endproperty
	a_sendStarts: assert property (p_sendStarts) else $error("send state started no frame");

	property p_takeLoads;
		@(posedge clk) disable iff (rst) takeCmd |=> (txByte_reg == $past(cmdData)) && (state_reg == ST_SEND);
	endproperty
	a_takeLoads: assert property (p_takeLoads) else $error("accepted command not loaded");

	property p_initLoads;
		@(posedge clk) disable iff (rst) (state_reg == ST_INIT) |=> (state_reg == ST_SEND) && (txByte_reg == INIT_CODE);
	endproperty
	a_initLoads: assert property (p_initLoads) else $error("init code not loaded first");

	property p_readyNeedsLink;
		@(posedge clk) disable iff (rst) cmdReady |-> linkUp_reg;
	endproperty
	a_readyNeedsLink: assert property (p_readyNeedsLink) else $error("command taken before link up");

	property p_readyWithStatus;
		@(posedge clk) disable iff (rst) $rose(cmdReady) |-> statusValid;
	endproperty
	a_readyWithStatus: assert property (p_readyWithStatus) else $error("ready without status answer");

	property p_statusPulse;
		@(posedge clk) disable iff (rst) statusValid |=> !statusValid;
	endproperty
	a_statusPulse: assert property (p_statusPulse) else $error("status valid longer than one cycle");

	// Status capture: data and error flag stand until the next answer
	property p_statusData;
		@(posedge clk) disable iff (rst) answerSeen |=> (statusData == $past(rxFrame.data));
	endproperty
	a_statusData: assert property (p_statusData) else $error("status byte not captured");

	property p_statusErr;
		@(posedge clk) disable iff (rst) answerSeen |=> (statusErr == $past(rxFrame.parityErr | rxFrame.stopErr));
	endproperty
	a_statusErr: assert property (p_statusErr) else $error("status error flag not captured");

	property p_statusHold;
		@(posedge clk) disable iff (rst) !answerSeen |=> $stable(statusData) && $stable(statusErr);
	endproperty
	a_statusHold: assert property (p_statusHold) else $error("status changed without answer");

	// Video: shifts only on its bit timer and stays idle between lines
	property p_lineShift;
		@(posedge clk) disable iff (rst) pixStep && !lineTake |=> (vid_reg == ($past(vid_reg) >> 1));
	endproperty
	a_lineShift: assert property (p_lineShift) else $error("video bit not advanced");

	property p_lineEnd;
		@(posedge clk) disable iff (rst) (pix_reg == '0) && !lineTake |=> (pix_reg == '0);
	endproperty
	a_lineEnd: assert property (p_lineEnd) else $error("video restarted without line sync");

	property p_lineGate;
		@(posedge clk) disable iff (rst) lineTake |-> inPage_reg && $rose(hsyncIn);
	endproperty
	a_lineGate: assert property (p_lineGate) else $error("line taken outside page or sync edge");

	property p_pageClose;
		@(posedge clk) disable iff (rst) !pageWanted && !vsRise |=> !inPage_reg;
	endproperty
	a_pageClose: assert property (p_pageClose) else $error("page kept open without request");
endmodule // ecl_link
`default_nettype wire

// *** tb/ecl_engine_model.sv ***
// Purpose: Engine-side model for the command/status link.
// Assumes: Status line is driven high by the model while idle.
// Notes:   Answers each command with its inverted byte.
`timescale 1ns/1ps
`default_nettype none
module ecl_engine_model import ecl_pkg::*; #(
	parameter int unsigned BIT_CYC = 16
) (
	input  wire logic       clk,
	input  wire logic       commandLine,
	input  wire logic       badParity,
	output logic            statusLine,
	output logic [7:0]      lastCmd,
	output logic            cmdOk,
	output logic [7:0]      cmdCnt,
	output logic            dupErr
);
	logic [9:0] fr;
	logic [9:0] sf;
	// Take a command at bit centres, then answer once its stop bit is seen
	initial begin
		statusLine = LINE_IDLE;
		{lastCmd, cmdOk, cmdCnt, dupErr} = '0;
		forever begin
			@(posedge clk);
			if (commandLine === 1'b0) begin
				repeat (BIT_CYC / 2) @(posedge clk);
				for (int i = 0; i < 10; i++) begin
					repeat (BIT_CYC) @(posedge clk);
					fr[i] = commandLine;
				end
				lastCmd = fr[7:0];
				cmdOk   = (^fr[8:0]) & fr[9];
				cmdCnt  = cmdCnt + 8'h01;
				// Let the command's stop bit run out so only one side sends at a time
				repeat (BIT_CYC / 2) @(posedge clk);
				// Parity can be spoiled on command of the bench
				sf = {~^(~fr[7:0]) ^ badParity, ~fr[7:0], 1'b0};
				for (int i = 0; i < 10; i++) begin
					statusLine <= sf[i];
					repeat (BIT_CYC) begin
						@(posedge clk);
						if (commandLine !== 1'b1) dupErr = 1'b1;
					end
				end
				// Stop bit is the idle level, so a prompt next command is not missed
				statusLine <= LINE_IDLE;
			end
		end
	end
endmodule // ecl_engine_model
`default_nettype wire

// *** tb/tb_engine_command_status_link.sv ***
// Purpose: Self-checking bench for the engine command/status link.
// Assumes: Bit period shortened to 16 clocks.
// Notes:   Rows hold a command beside the status it should bring back.
`timescale 1ns/1ps
`default_nettype none
module tb_engine_command_status_link import ecl_pkg::*;;
	localparam int unsigned BC = 16;
	typedef struct packed {
		logic [7:0] cmd;
		logic       bad;
		logic [7:0] st;
		logic       err;
	} ecl_row_t;
	ecl_row_t    rows [4] = '{'{8'h01, 1'b0, 8'hfe, 1'b0}, '{8'h80, 1'b1, 8'h7f, 1'b1},
	                          '{8'hff, 1'b0, 8'h00, 1'b0}, '{8'h55, 1'b0, 8'haa, 1'b0}};
	logic        clk = 1'b0;
	logic        rst, cmdValid, cmdReady, statusValid, statusErr, linkUp, pageWanted;
	logic        lineTake, pageStart, engineReadyInd, keyStatus, vsyncIn, hsyncIn;
	logic        statusLine, commandLine, printRequest, videoOut, badParity, cmdOk, dupErr;
	logic [7:0]  cmdData, statusData, lastCmd, cmdCnt;
	logic [15:0] lineBits;
	ecl_side_t   sideState;
	int          errorCnt = 0;
	int          testsRun = 0;

	always #2.5 clk = ~clk;

	ecl_link #(.BIT_CYC(BC)) i_dut (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdData(cmdData),
		.cmdReady(cmdReady), .statusData(statusData), .statusValid(statusValid), .statusErr(statusErr),
		.linkUp(linkUp), .pageWanted(pageWanted), .lineBits(lineBits), .lineTake(lineTake),
		.pageStart(pageStart), .sideState(sideState), .engineReadyInd(engineReadyInd),
		.keyStatus(keyStatus), .vsyncIn(vsyncIn), .hsyncIn(hsyncIn), .statusLine(statusLine),
		.commandLine(commandLine), .printRequest(printRequest), .videoOut(videoOut));

	ecl_engine_model #(.BIT_CYC(BC)) i_eng (.clk(clk), .commandLine(commandLine), .badParity(badParity),
		.statusLine(statusLine), .lastCmd(lastCmd), .cmdOk(cmdOk), .cmdCnt(cmdCnt), .dupErr(dupErr));

	// Verdict and end of run, shared by the timeouts
	task automatic finishTest();
		if (errorCnt == 0 && testsRun > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One settled step; a hang counts as a mismatch
	task automatic tick(inout int n);
		@(posedge clk);
		#1;
		n++;
		if (n > 2000) begin
			errorCnt++;
			finishTest();
		end
	endtask

	task automatic waitStatus();
		int n;
		n = 0;
		while (statusValid !== 1'b1) tick(n);
	endtask

	// Request held until the edge that sees cmdReady high
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdData  <= b;
		#1;
		while (cmdReady !== 1'b1) tick(n);
		@(posedge clk);
		cmdValid <= 1'b0;
	endtask

	initial begin
		{rst, cmdValid, keyStatus, vsyncIn, hsyncIn, badParity, cmdData} = '0;
		{rst, pageWanted, engineReadyInd} = 3'h7;
		lineBits = 16'ha5c3;
		repeat (20) @(posedge clk);
		#1;
		chk("commandLine", commandLine, 1'b1);
		chk("cmdReady", cmdReady, 1'b0);
		chk("printRequest", printRequest, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		waitStatus();
		chk("lastCmd", lastCmd, INIT_CMD);
		// Ordinary traffic, one bad parity answer among it
		foreach (rows[i]) begin
			badParity <= rows[i].bad;
			send(rows[i].cmd);
			waitStatus();
			chk("lastCmd", lastCmd, rows[i].cmd);
			chk("cmdOk", cmdOk, 1'b1);
			chk("statusData", statusData, rows[i].st);
			chk("statusErr", statusErr, rows[i].err);
		end
		chk("linkUp", linkUp, 1'b1);
		chk("cmdCnt", cmdCnt, 8'h05);
		// Every ready and request combination
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			{pageWanted, engineReadyInd} <= 2'(k);
			keyStatus <= k[0];
			#1;
			chk("printRequest", printRequest, k == 3);
			chk("sideState", sideState, {engineReadyInd, keyStatus, vsyncIn, hsyncIn});
		end
		// A line sync before the page sync starts no line
		@(posedge clk);
		hsyncIn <= 1'b1;
		#1;
		chk("lineTake", lineTake, 1'b0);
		@(posedge clk);
		hsyncIn <= 1'b0;
		@(posedge clk);
		vsyncIn <= 1'b1;
		#1;
		chk("pageStart", pageStart, 1'b1);
		@(posedge clk);
		hsyncIn <= 1'b1;
		#1;
		chk("lineTake", lineTake, 1'b1);
		repeat (1 + BC / 2) @(posedge clk);
		for (int i = 0; i <= 16; i++) begin
			#1;
			chk("videoOut", videoOut, (i < 16) ? lineBits[i] : 1'b0);
			repeat (BC) @(posedge clk);
		end
		// A command offered while busy is refused
		send(8'h3c);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdData  <= 8'hc3;
		repeat (20) @(posedge clk);
		cmdValid <= 1'b0;
		waitStatus();
		chk("lastCmd", lastCmd, 8'h3c);
		chk("statusData", statusData, 8'hc3);
		chk("dupErr", dupErr, 1'b0);
		// Second reset in mid-run repeats the init command
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("linkUp", linkUp, 1'b0);
		chk("cmdReady", cmdReady, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		waitStatus();
		chk("lastCmd", lastCmd, INIT_CMD);
		chk("cmdCnt", cmdCnt, 8'h07);
		finishTest();
	end
endmodule // tb_engine_command_status_link
`default_nettype wire
